// ==== logic/cowc_top.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "cowc_cfg.svh"

module cowc_top (
   // Clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   // Counter block, same clock
   input  wire logic [15:0] counter_value,
   input  wire logic        counter_at_top,
   input  wire logic        counter_down,
   // Compare pins
   output logic             compare_pin_a,
   output logic             compare_pin_a_en,
   output logic             compare_pin_b,
   output logic             compare_pin_b_en,
   output logic             compare_pin_c,
   output logic             compare_pin_c_en
);

   localparam int NCH = `COWC_CHANNELS;

   // Register index decode, shared by read and write paths
   typedef enum logic [2:0] {
      cowc_reg_mode,
      cowc_reg_comp,
      cowc_reg_val_a,
      cowc_reg_val_b,
      cowc_reg_val_c,
      cowc_reg_stat,
      cowc_reg_none
   } cowc_reg_e;

   function automatic cowc_reg_e reg_of(input logic [7:0] a);
      case (a)
         `COWC_OFF_MODE:      reg_of = cowc_reg_mode;
         `COWC_OFF_COMP_MODE: reg_of = cowc_reg_comp;
         `COWC_OFF_VALUE_A:   reg_of = cowc_reg_val_a;
         `COWC_OFF_VALUE_B:   reg_of = cowc_reg_val_b;
         `COWC_OFF_VALUE_C:   reg_of = cowc_reg_val_c;
         `COWC_OFF_STATUS:    reg_of = cowc_reg_stat;
         default:             reg_of = cowc_reg_none;
      endcase
   endfunction

   // Waveform mode to group
   function automatic cowc_pkg::cowc_group_e group_of(input logic [3:0] w);
      case (w)
         `COWC_WGM_NORMAL,
         `COWC_WGM_CTC_OCR,
         `COWC_WGM_CTC_ICR:  group_of = cowc_pkg::grp_non_pwm;
         `COWC_WGM_FAST_8,
         `COWC_WGM_FAST_9,
         `COWC_WGM_FAST_10,
         `COWC_WGM_FAST_ICR,
         `COWC_WGM_FAST_OCR: group_of = cowc_pkg::grp_fast_pwm;
         `COWC_WGM_RSVD:     group_of = cowc_pkg::grp_reserved;
         default:            group_of = cowc_pkg::grp_phase_pwm;
      endcase
   endfunction

   // Software state
   logic [3:0]                waveform_mode_select_q;
   logic [3:0]                waveform_mode_select_d;
   logic [5:0]                compare_output_mode_q;
   logic [5:0]                compare_output_mode_d;
   cowc_pkg::cowc_value_t     compare_value_q [NCH];
   cowc_pkg::cowc_value_t     compare_value_d [NCH];

   // Bus answer state
   logic [31:0]               prdata_q;
   logic [31:0]               prdata_d;
   logic                      pready_q;
   logic                      pready_d;
   logic                      pslverr_q;
   logic                      pslverr_d;

   // Derived signals
   cowc_reg_e                 sel_reg;
   logic                      wr_take;
   cowc_pkg::cowc_group_e     group;
   logic [NCH-1:0]            match;
   logic [NCH-1:0]            toggle_ok;
   logic [NCH-1:0]            level;
   logic [NCH-1:0]            attached;

   assign sel_reg = reg_of(paddr);
   // Write lands only at the completing access edge
   assign wr_take = psel && penable && pready_q && pwrite && (sel_reg != cowc_reg_none);

   // Group decode steers every channel's interpretation
   assign group = group_of(waveform_mode_select_q);

   // Per-channel compare match and toggle permission
   always_comb begin
      for (int i = 0; i < NCH; i++) begin
         match[i] = (counter_value == compare_value_q[i]);
      end
      case (group)
         cowc_pkg::grp_non_pwm: toggle_ok = {NCH{1'b1}};
         cowc_pkg::grp_fast_pwm: begin
            // Only channel A may toggle, and only with TOP from a register
            toggle_ok = {2'b00, waveform_mode_select_q >= `COWC_WGM_FAST_ICR};
         end
         cowc_pkg::grp_phase_pwm: begin
            toggle_ok = {2'b00, waveform_mode_select_q >= `COWC_WGM_PFC_LO
                              && waveform_mode_select_q <= `COWC_WGM_PFC_HI};
         end
         default: toggle_ok = {NCH{1'b0}};
      endcase
   end

   // Register write next values
   always_comb begin
      waveform_mode_select_d = waveform_mode_select_q;
      compare_output_mode_d  = compare_output_mode_q;
      for (int i = 0; i < NCH; i++) begin
         compare_value_d[i] = compare_value_q[i];
      end
      if (wr_take) begin
         case (sel_reg)
            cowc_reg_mode:  waveform_mode_select_d = pwdata[3:0];
            cowc_reg_comp:  compare_output_mode_d  = pwdata[5:0];
            cowc_reg_val_a: compare_value_d[0]     = pwdata[15:0];
            cowc_reg_val_b: compare_value_d[1]     = pwdata[15:0];
            cowc_reg_val_c: compare_value_d[2]     = pwdata[15:0];
            default:        waveform_mode_select_d = waveform_mode_select_q;
         endcase
      end
   end

   // Register write storage
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         waveform_mode_select_q <= `COWC_WGM_RESET;
         compare_output_mode_q  <= `COWC_COM_RESET;
         for (int i = 0; i < NCH; i++) begin
            compare_value_q[i] <= `COWC_VALUE_RESET;
         end
      end else begin
         waveform_mode_select_q <= waveform_mode_select_d;
         compare_output_mode_q  <= compare_output_mode_d;
         for (int i = 0; i < NCH; i++) begin
            compare_value_q[i] <= compare_value_d[i];
         end
      end
   end

   // Bus answer: no wait state; pready and read data come from flops loaded in the setup cycle
   always_comb begin
      pready_d  = psel && !penable;
      prdata_d  = prdata_q;
      pslverr_d = 1'b0;
      if (psel && !penable) begin
         prdata_d = 32'h0000_0000;
         case (sel_reg)
            cowc_reg_mode:  prdata_d[3:0]  = waveform_mode_select_q;
            cowc_reg_comp:  prdata_d[5:0]  = compare_output_mode_q;
            cowc_reg_val_a: prdata_d[15:0] = compare_value_q[0];
            cowc_reg_val_b: prdata_d[15:0] = compare_value_q[1];
            cowc_reg_val_c: prdata_d[15:0] = compare_value_q[2];
            cowc_reg_stat: begin
               prdata_d[2:0] = level;
               prdata_d[5:3] = attached;
            end
            default:        pslverr_d = 1'b1;
         endcase
      end
   end

   // Bus answer registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_q  <= 32'h0000_0000;
         pready_q  <= 1'b0;
         pslverr_q <= 1'b0;
      end else begin
         prdata_q  <= prdata_d;
         pready_q  <= pready_d;
         pslverr_q <= pslverr_d;
      end
   end

   assign prdata  = prdata_q;
   assign pready  = pready_q;
   assign pslverr = pslverr_q;

   // One action unit per channel
   for (genvar g = 0; g < NCH; g++) begin : g_ch
      cowc_channel u_ch (
         .pclk                (pclk),
         .presetn             (presetn),
         .group               (group),
         .compare_output_mode (compare_output_mode_q[2*g +: 2]),
         .toggle_ok           (toggle_ok[g]),
         .match               (match[g]),
         .at_top              (counter_at_top),
         .count_down          (counter_down),
         .level               (level[g]),
         .attached            (attached[g])
      );
   end

   // Pins: level from flops, enable while the channel owns the pin
   assign compare_pin_a    = level[0];
   assign compare_pin_b    = level[1];
   assign compare_pin_c    = level[2];
   assign compare_pin_a_en = attached[0];
   assign compare_pin_b_en = attached[1];
   assign compare_pin_c_en = attached[2];

   match_set_a:
   assert property (@(posedge pclk) disable iff (!presetn)
      group == cowc_pkg::grp_non_pwm && compare_output_mode_q[1:0] == `COWC_COM_SET
      && counter_value == compare_value_q[0] |=> compare_pin_a)
      else $error("match on channel A did not set pin");

   nonpwm_toggle_a:
   assert property (@(posedge pclk) disable iff (!presetn)
      group == cowc_pkg::grp_non_pwm && compare_output_mode_q[1:0] == `COWC_COM_TOGGLE
      && match[0] |=> compare_pin_a != $past(compare_pin_a))
      else $error("non-PWM toggle on A missing");

   fast_b_detach_a:
   assert property (@(posedge pclk) disable iff (!presetn)
      group == cowc_pkg::grp_fast_pwm && compare_output_mode_q[3:2] == `COWC_COM_TOGGLE
      |-> !compare_pin_b_en)
      else $error("fast PWM toggle code attached channel B");

   phase_a_toggle_a:
   assert property (@(posedge pclk) disable iff (!presetn)
      group == cowc_pkg::grp_phase_pwm && compare_output_mode_q[1:0] == `COWC_COM_TOGGLE
      |-> compare_pin_a_en == (waveform_mode_select_q <= `COWC_WGM_PFC_HI
                               && waveform_mode_select_q >= `COWC_WGM_PFC_LO))
      else $error("phase PWM toggle gating on A wrong");

   fast_pwm_cycle_a:
   assert property (@(posedge pclk) disable iff (!presetn)
      group == cowc_pkg::grp_fast_pwm && compare_output_mode_q[1:0] == `COWC_COM_CLEAR
      && match[0] && !counter_at_top ##1 $stable(compare_output_mode_q) && $stable(waveform_mode_select_q)
      && counter_at_top
      |-> !compare_pin_a ##1 compare_pin_a)
      else $error("fast PWM clear then set on A wrong");

   fast_inv_a:
   assert property (@(posedge pclk) disable iff (!presetn)
      group == cowc_pkg::grp_fast_pwm && compare_output_mode_q[5:4] == `COWC_COM_SET
      && match[2] && !counter_at_top |=> compare_pin_c)
      else $error("fast PWM set on match on C wrong");

   bus_answer_a:
   assert property (@(posedge pclk) disable iff (!presetn)
      psel && !penable |=> pready && (pslverr == ($past(sel_reg) == cowc_reg_none)))
      else $error("APB answer timing or error wrong");

   reserved_detach_a:
   assert property (@(posedge pclk) disable iff (!presetn)
      group == cowc_pkg::grp_reserved
      |-> !compare_pin_a_en && !compare_pin_b_en && !compare_pin_c_en)
      else $error("reserved mode left a pin attached");

   fast_a_toggle_a:
   assert property (@(posedge pclk) disable iff (!presetn)
      group == cowc_pkg::grp_fast_pwm && compare_output_mode_q[1:0] == `COWC_COM_TOGGLE
      && match[0] && waveform_mode_select_q >= `COWC_WGM_FAST_ICR
      |=> compare_pin_a != $past(compare_pin_a))
      else $error("fast PWM toggle on A missing");

   phase_c_detach_a:
   assert property (@(posedge pclk) disable iff (!presetn)
      group == cowc_pkg::grp_phase_pwm && compare_output_mode_q[5:4] == `COWC_COM_TOGGLE
      |-> !compare_pin_c_en)
      else $error("phase PWM toggle code attached channel C");

   comp_write_a:
   assert property (@(posedge pclk) disable iff (!presetn)
      psel && penable && pready && pwrite && sel_reg == cowc_reg_comp
      |=> compare_output_mode_q == $past(pwdata[5:0]))
      else $error("mode code write did not land");

endmodule

`default_nettype wire

// ==== logic/cowc_cfg.svh ====
`ifndef COWC_CFG_SVH
`define COWC_CFG_SVH

// Register byte offsets
`define COWC_OFF_MODE      8'h00
`define COWC_OFF_COMP_MODE 8'h04
`define COWC_OFF_VALUE_A   8'h08
`define COWC_OFF_VALUE_B   8'h0C
`define COWC_OFF_VALUE_C   8'h10
`define COWC_OFF_STATUS    8'h14

// Field layout
`define COWC_WGM_W         4
`define COWC_COM_W         2
`define COWC_VALUE_W       16
`define COWC_CHANNELS      3
`define COWC_STAT_EN_LSB   3

// Reset values
`define COWC_WGM_RESET     4'h0
`define COWC_COM_RESET     6'h00
`define COWC_VALUE_RESET   16'h0000

// Waveform mode numbers
`define COWC_WGM_NORMAL    4'h0
`define COWC_WGM_CTC_OCR   4'h4
`define COWC_WGM_CTC_ICR   4'hC
`define COWC_WGM_RSVD      4'hD
`define COWC_WGM_FAST_8    4'h5
`define COWC_WGM_FAST_9    4'h6
`define COWC_WGM_FAST_10   4'h7
`define COWC_WGM_FAST_ICR  4'hE
`define COWC_WGM_FAST_OCR  4'hF
`define COWC_WGM_PFC_LO    4'h8
`define COWC_WGM_PFC_HI    4'hB

// Compare output mode codes
`define COWC_COM_OFF       2'h0
`define COWC_COM_TOGGLE    2'h1
`define COWC_COM_CLEAR     2'h2
`define COWC_COM_SET       2'h3

`endif

// ==== logic/cowc_pkg.sv ====
package cowc_pkg;

   // Waveform mode groups that decide compare output meaning
   typedef enum logic [1:0] {
      grp_non_pwm,
      grp_fast_pwm,
      grp_phase_pwm,
      grp_reserved
   } cowc_group_e;

   typedef logic [1:0]  cowc_com_t;
   typedef logic [15:0] cowc_value_t;

endpackage

// ==== logic/cowc_channel.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "cowc_cfg.svh"

module cowc_channel (
   // Clock and reset
   input  wire logic                 pclk,
   input  wire logic                 presetn,
   // Mode selection
   input  wire cowc_pkg::cowc_group_e group,
   input  wire cowc_pkg::cowc_com_t  compare_output_mode,
   input  wire logic                 toggle_ok,
   // Counter events
   input  wire logic                 match,
   input  wire logic                 at_top,
   input  wire logic                 count_down,
   // Pin side
   output logic                      level,
   output logic                      attached
);

   logic level_q;
   logic level_d;

   // Pin taken from the port only for a live mode code
   always_comb begin
      attached = (compare_output_mode != `COWC_COM_OFF)
              && !(compare_output_mode == `COWC_COM_TOGGLE && !toggle_ok)
              && (group != cowc_pkg::grp_reserved);
   end

   // Next output level per mode group
   always_comb begin
      level_d = level_q;
      case (group)
         cowc_pkg::grp_non_pwm: begin
            if (match) begin
               case (compare_output_mode)
                  `COWC_COM_TOGGLE: level_d = ~level_q;
                  `COWC_COM_CLEAR:  level_d = 1'b0;
                  `COWC_COM_SET:    level_d = 1'b1;
                  default:          level_d = level_q;
               endcase
            end
         end
         cowc_pkg::grp_fast_pwm: begin
            // TOP action first: a match at TOP is dropped in PWM codes
            if (compare_output_mode[1] && at_top) begin
               level_d = ~compare_output_mode[0];
            end else if (match) begin
               if (compare_output_mode == `COWC_COM_TOGGLE) begin
                  level_d = toggle_ok ? ~level_q : level_q;
               end else if (compare_output_mode[1]) begin
                  level_d = compare_output_mode[0];
               end
            end
         end
         cowc_pkg::grp_phase_pwm: begin
            if (match) begin
               if (compare_output_mode == `COWC_COM_TOGGLE) begin
                  level_d = toggle_ok ? ~level_q : level_q;
               end else if (compare_output_mode[1]) begin
                  // Direction picks set or clear
                  level_d = count_down ^ compare_output_mode[0];
               end
            end
         end
         default: level_d = level_q;
      endcase
   end

   // Output level register; held while detached so reattach is glitch free
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         level_q <= 1'b0;
      end else begin
         level_q <= level_d;
      end
   end

   assign level = level_q;

   detach_zero_a:
   assert property (@(posedge pclk) disable iff (!presetn)
      compare_output_mode == `COWC_COM_OFF |-> !attached)
      else $error("detached code still drives pin");

   nonpwm_clear_a:
   assert property (@(posedge pclk) disable iff (!presetn)
      group == cowc_pkg::grp_non_pwm && compare_output_mode == `COWC_COM_CLEAR && match |=> !level_q)
      else $error("non-PWM clear on match failed");

   nonpwm_set_a:
   assert property (@(posedge pclk) disable iff (!presetn)
      group == cowc_pkg::grp_non_pwm && compare_output_mode == `COWC_COM_SET && match |=> level_q)
      else $error("non-PWM set on match failed");

   fast_top_a:
   assert property (@(posedge pclk) disable iff (!presetn)
      group == cowc_pkg::grp_fast_pwm && compare_output_mode[1] && at_top
      |=> level_q == ~$past(compare_output_mode[0]))
      else $error("fast PWM TOP action wrong");

   phase_dir_a:
   assert property (@(posedge pclk) disable iff (!presetn)
      group == cowc_pkg::grp_phase_pwm && compare_output_mode == `COWC_COM_CLEAR && match
      |=> level_q == $past(count_down))
      else $error("phase PWM clear/set by direction wrong");

   phase_inv_a:
   assert property (@(posedge pclk) disable iff (!presetn)
      group == cowc_pkg::grp_phase_pwm && compare_output_mode == `COWC_COM_SET && match
      |=> level_q == !$past(count_down))
      else $error("phase PWM inverting action wrong");

endmodule

`default_nettype wire

// ==== tb/cowc_pin_load.sv ====
`timescale 1ns/10ps
`default_nettype none

// Pad seen by the board: the port's weak pull-down wins while the channel is detached,
// so a stale level is never mistaken for a driven one
module cowc_pin_load (
   // Channel side
   input  wire logic drive,
   input  wire logic en,
   // Board side
   output logic      pad
);
   // Driven level only while attached
   assign pad = en ? drive : 1'b0;
endmodule

`default_nettype wire

// ==== tb/cowc_top_tb.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "cowc_cfg.svh"

`define CHK(nm, ex, got) begin cmp_count++; if ((got) !== (ex)) begin fail_count++; \
   $display("[ERR] %s expected %h seen %h", nm, ex, got); end end

module cowc_top_tb;
   // One row: mode, code for all channels, counter event, pads {ena,a,enb,b,enc,c}
   typedef struct packed {
      logic [3:0]  w;
      logic [1:0]  c;
      logic [15:0] cv;
      logic        t;
      logic        dn;
      logic [5:0]  ex;
   } cowc_row_s;

   // Idle count never equals any compare value used here
   localparam logic [15:0] idle_count = 16'h7777;

   logic        pclk;
   logic        presetn;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [7:0]  paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic [15:0] counter_value;
   logic        counter_at_top;
   logic        counter_down;
   logic [2:0]  lvl;
   logic [2:0]  en;
   logic [2:0]  pad;
   logic [31:0] q;
   logic        e;
   int          fail_count;
   int          cmp_count;

   // Level sequence carries over from row to row
   cowc_row_s rows [26] = '{
      '{4'h0, 2'h3, 16'h0005, 1'b0, 1'b0, 6'h3F},
      '{4'h0, 2'h2, 16'h0005, 1'b0, 1'b0, 6'h2A},
      '{4'h0, 2'h1, 16'h0005, 1'b0, 1'b0, 6'h3F},
      '{4'h4, 2'h1, 16'h0005, 1'b0, 1'b0, 6'h2A},
      '{4'hC, 2'h1, 16'h0005, 1'b0, 1'b0, 6'h3F},
      '{4'h0, 2'h1, 16'h0006, 1'b0, 1'b0, 6'h3F},
      '{4'h0, 2'h0, 16'h0005, 1'b0, 1'b0, 6'h00},
      '{4'h5, 2'h2, 16'h0005, 1'b0, 1'b0, 6'h2A},
      '{4'h5, 2'h2, 16'h0005, 1'b1, 1'b0, 6'h3F},
      '{4'h5, 2'h3, 16'h0005, 1'b1, 1'b0, 6'h2A},
      '{4'h5, 2'h3, 16'h0005, 1'b0, 1'b0, 6'h3F},
      '{4'h5, 2'h3, 16'h0006, 1'b1, 1'b0, 6'h2A},
      '{4'h7, 2'h2, 16'h0006, 1'b1, 1'b0, 6'h3F},
      '{4'h6, 2'h1, 16'h0005, 1'b0, 1'b0, 6'h00},
      '{4'hE, 2'h1, 16'h0005, 1'b0, 1'b0, 6'h20},
      '{4'hF, 2'h1, 16'h0005, 1'b0, 1'b0, 6'h30},
      '{4'h8, 2'h1, 16'h0005, 1'b0, 1'b0, 6'h20},
      '{4'h9, 2'h1, 16'h0005, 1'b0, 1'b0, 6'h30},
      '{4'hA, 2'h1, 16'h0005, 1'b0, 1'b0, 6'h20},
      '{4'hB, 2'h1, 16'h0005, 1'b0, 1'b0, 6'h30},
      '{4'h1, 2'h1, 16'h0005, 1'b0, 1'b0, 6'h00},
      '{4'h2, 2'h2, 16'h0005, 1'b0, 1'b0, 6'h2A},
      '{4'h3, 2'h2, 16'h0005, 1'b0, 1'b1, 6'h3F},
      '{4'hA, 2'h3, 16'h0005, 1'b0, 1'b1, 6'h2A},
      '{4'hA, 2'h3, 16'h0005, 1'b0, 1'b0, 6'h3F},
      '{4'hD, 2'h3, 16'h0005, 1'b0, 1'b0, 6'h00}
   };

   cowc_top dut (
      .pclk             (pclk),
      .presetn          (presetn),
      .psel             (psel),
      .penable          (penable),
      .pwrite           (pwrite),
      .paddr            (paddr),
      .pwdata           (pwdata),
      .prdata           (prdata),
      .pready           (pready),
      .pslverr          (pslverr),
      .counter_value    (counter_value),
      .counter_at_top   (counter_at_top),
      .counter_down     (counter_down),
      .compare_pin_a    (lvl[0]),
      .compare_pin_a_en (en[0]),
      .compare_pin_b    (lvl[1]),
      .compare_pin_b_en (en[1]),
      .compare_pin_c    (lvl[2]),
      .compare_pin_c_en (en[2])
   );

   cowc_pin_load load [2:0] (
      .drive (lvl),
      .en    (en),
      .pad   (pad)
   );

   // 20 MHz clock
   always #25 pclk = ~pclk;

   // Single place where the run ends
   task automatic give_verdict;
      $display("compares %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   // One APB transfer; answer lands in q and e at the completion edge
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 16);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (pready !== 1'b1) begin
         fail_count++;
         $display("[ERR] pready expected 1 seen %b", pready);
         give_verdict();
      end
   endtask

   // Counter event for one cycle, then look once the pins have settled
   task automatic ev(input logic [15:0] cv, input logic t, input logic dn);
      @(posedge pclk);
      counter_value <= cv;
      counter_at_top <= t;
      counter_down <= dn;
      @(posedge pclk);
      counter_value <= idle_count;
      counter_at_top <= 1'b0;
      @(negedge pclk);
   endtask

   initial begin
      pclk = 1'b0;
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h00000000;
      counter_value = idle_count;
      counter_at_top = 1'b0;
      counter_down = 1'b0;
      fail_count = 0;
      cmp_count = 0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      @(negedge pclk);
      `CHK("pads after reset", 6'h00, {en[0], pad[0], en[1], pad[1], en[2], pad[2]})
      apb(1'b1, `COWC_OFF_VALUE_A, 32'h00000005);
      apb(1'b1, `COWC_OFF_VALUE_B, 32'h00000005);
      apb(1'b1, `COWC_OFF_VALUE_C, 32'h00000005);
      // Table of mode and event cases
      foreach (rows[i]) begin
         apb(1'b1, `COWC_OFF_MODE, {28'h0000000, rows[i].w});
         apb(1'b1, `COWC_OFF_COMP_MODE, {26'h0000000, {3{rows[i].c}}});
         ev(rows[i].cv, rows[i].t, rows[i].dn);
         `CHK("pads", rows[i].ex, {en[0], pad[0], en[1], pad[1], en[2], pad[2]})
      end
      // Distinct compare values: only channel B matches
      apb(1'b1, `COWC_OFF_MODE, 32'h00000000);
      apb(1'b1, `COWC_OFF_COMP_MODE, 32'h00000015);
      apb(1'b1, `COWC_OFF_VALUE_B, 32'h00000006);
      ev(16'h0006, 1'b0, 1'b0);
      `CHK("pads b only", 6'h3B, {en[0], pad[0], en[1], pad[1], en[2], pad[2]})
      apb(1'b0, `COWC_OFF_STATUS, 32'h00000000);
      `CHK("status", 33'h00000003D, {e, q})
      apb(1'b1, `COWC_OFF_STATUS, 32'h00000000);
      apb(1'b0, `COWC_OFF_STATUS, 32'h00000000);
      `CHK("status kept", 33'h00000003D, {e, q})
      apb(1'b0, `COWC_OFF_VALUE_B, 32'h00000000);
      `CHK("value b", 33'h000000006, {e, q})
      // Unmapped place answers with an error and zero data
      apb(1'b0, 8'h18, 32'h00000000);
      `CHK("unmapped read", 33'h100000000, {e, q})
      apb(1'b1, 8'h18, 32'hFFFFFFFF);
      `CHK("unmapped write", 1'b1, e)
      // Fast PWM clear: match one cycle, TOP the next, as a real count gives it
      apb(1'b1, `COWC_OFF_MODE, 32'h00000005);
      apb(1'b1, `COWC_OFF_COMP_MODE, 32'h0000002A);
      apb(1'b0, `COWC_OFF_MODE, 32'h00000000);
      `CHK("mode readback", 33'h000000005, {e, q})
      apb(1'b0, `COWC_OFF_COMP_MODE, 32'h00000000);
      `CHK("code readback", 33'h00000002A, {e, q})
      @(posedge pclk);
      counter_value <= 16'h0005;
      @(posedge pclk);
      counter_value <= 16'h03FF;
      counter_at_top <= 1'b1;
      @(negedge pclk);
      `CHK("pads fast match", 6'h2A, {en[0], pad[0], en[1], pad[1], en[2], pad[2]})
      @(posedge pclk);
      counter_value <= idle_count;
      counter_at_top <= 1'b0;
      @(negedge pclk);
      `CHK("pads fast top", 6'h3F, {en[0], pad[0], en[1], pad[1], en[2], pad[2]})
      // Reset in mid-run detaches everything again
      @(posedge pclk);
      presetn <= 1'b0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      @(negedge pclk);
      `CHK("pads after second reset", 6'h00, {en[0], pad[0], en[1], pad[1], en[2], pad[2]})
      apb(1'b0, `COWC_OFF_COMP_MODE, 32'h00000000);
      `CHK("mode codes reset", 33'h000000000, {e, q})
      apb(1'b0, `COWC_OFF_VALUE_B, 32'h00000000);
      `CHK("value b reset", 33'h000000000, {e, q})
      give_verdict();
   end
endmodule

`default_nettype wire
